/* File: src/dpsr_pkg.sv */
package dpsr_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int DPSR_ADAPTERS = 6;
  localparam int DPSR_VAL_W = 16;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] DPSR_OFS_RATE = 8'h00;
  localparam logic [7:0] DPSR_OFS_CFG = 8'h04;
  localparam logic [7:0] DPSR_OFS_POT_MASK = 8'h08;
  localparam logic [7:0] DPSR_OFS_LOGIC_MASK = 8'h0C;
  localparam logic [7:0] DPSR_OFS_VALUE = 8'h10;
  localparam logic [7:0] DPSR_OFS_UP_OWNER = 8'h14;
  localparam logic [7:0] DPSR_OFS_DOWN_OWNER = 8'h18;
  localparam logic [7:0] DPSR_OFS_STATUS = 8'h1C;

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int DPSR_CFG_SAVE_BIT = 0;
  localparam int DPSR_CFG_STOP_KEEP_BIT = 1;
  localparam logic [1:0] DPSR_CFG_RST = 2'h2;
  localparam logic [15:0] DPSR_RATE_RST = 16'h0064;
  localparam logic [DPSR_ADAPTERS-1:0] DPSR_MASK_RST = '1;
  localparam logic signed [15:0] DPSR_VALUE_MAX = 16'sh0FA0;

  // ----------------------------------------------------------------
  // timing: control tick and fractional divider
  // ----------------------------------------------------------------
  localparam int DPSR_CLK_HZ = 25000000;
  localparam int DPSR_TICK_US = 1000;
  localparam int DPSR_TICK_CYCLES = (DPSR_CLK_HZ / 1000000) * DPSR_TICK_US;
  localparam logic [16:0] DPSR_FRAC_DIV = 17'(1000000 / DPSR_TICK_US);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    DPSR_INIT = 1'b0,
    DPSR_RUN = 1'b1
  } dpsr_phase_t;

  typedef struct packed {
    dpsr_phase_t phase;
    logic [15:0] rate;
    logic [1:0] cfg;
    logic [DPSR_ADAPTERS-1:0] potMask;
    logic [DPSR_ADAPTERS-1:0] logicMask;
    logic signed [15:0] value;
    logic [16:0] frac;
    logic [15:0] tickCnt;
    logic stopPrev;
    logic pwrPrev;
    logic [DPSR_ADAPTERS:0] upOwner;
    logic [DPSR_ADAPTERS:0] downOwner;
    logic [31:0] rdData;
    logic nvWr;
    logic signed [15:0] nvValue;
    logic nvSave;
    logic signed [15:0] valueOut;
    logic signed [15:0] target;
  } dpsr_state_t;

  localparam dpsr_state_t DPSR_RESET_STATE = '{
    phase: DPSR_INIT,
    rate: DPSR_RATE_RST,
    cfg: DPSR_CFG_RST,
    potMask: DPSR_MASK_RST,
    logicMask: DPSR_MASK_RST,
    default: '0
  };

endpackage : dpsr_pkg

/* File: src/dpsr_top.sv */
`timescale 1ns/1ps

// Contract
// - active command moves the reference linearly at the programmed 0.1 Hz per second rate
// - up and down commands are levels; change continues while held
// - one shared rate for both directions
// - up and down together leave the reference unchanged
// - reference is only a target for the downstream ramp
// - config bit 0 saves the reference at power loss and reloads it
// - rate and config writes take effect at once, also while running
// - config bit 1 clear means stop edge zeroes the reference
// - stop clear happens once per edge, even when already stopped
// - faults never clear the reference
// - adapter commands count only when pot and logic masks both allow
// - an assigned terminal input claims ownership when asserted
// - ownership is granted whether or not the pot is the speed source
// - speed source selection lies outside this block
// - present reference is published read-only in 0.1 Hz units
// - unipolar mode: decrement stops at zero
// - bipolar mode: decrement may go negative
// - switching to unipolar with a negative reference forces zero
// - pot permission mask holds one bit per adapter
// - owner bits are high while their source issues the command
module dpsr_top
  import dpsr_pkg::*;
#(
  parameter logic [15:0] TICK_CYCLES = 16'(DPSR_TICK_CYCLES)
)
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrStrobe,
  input wire logic regRdStrobe,
  output logic [31:0] regRdData,
  input wire logic tbUpIn,
  input wire logic tbDownIn,
  input wire logic tbAssignUp,
  input wire logic tbAssignDown,
  input wire logic [DPSR_ADAPTERS-1:0] adapterUpReq,
  input wire logic [DPSR_ADAPTERS-1:0] adapterDownReq,
  input wire logic stopIn,
  input wire logic unipolarMode,
  input wire logic powerDownIn,
  input wire logic nvLoadValid,
  input wire logic nvLoadSave,
  input wire logic signed [15:0] nvLoadValue,
  output logic nvWriteStrobe,
  output logic signed [15:0] nvWriteValue,
  output logic nvWriteSave,
  output logic signed [15:0] potValueOut,
  output logic signed [15:0] rampTargetOut,
  output logic [DPSR_ADAPTERS:0] upOwner,
  output logic [DPSR_ADAPTERS:0] downOwner
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  dpsr_state_t s;
  dpsr_state_t next_s;

  logic [DPSR_ADAPTERS-1:0] adapterUpOk;
  logic [DPSR_ADAPTERS-1:0] adapterDownOk;
  logic tbUpOk;
  logic tbDownOk;
  logic upAny;
  logic downAny;
  logic stopEdge;
  logic stopClear;
  logic pwrEdge;
  logic tick;
  logic negUnipolar;

  // ----------------------------------------------------------------
  // command qualification
  // ----------------------------------------------------------------
  // adapters need both masks; masks only gate, they never own
  assign adapterUpOk = adapterUpReq & s.potMask & s.logicMask;
  assign adapterDownOk = adapterDownReq & s.potMask & s.logicMask;
  // terminal inputs claim ownership regardless of the active source
  assign tbUpOk = tbUpIn & tbAssignUp;
  assign tbDownOk = tbDownIn & tbAssignDown;
  assign upAny = tbUpOk | (|adapterUpOk);
  assign downAny = tbDownOk | (|adapterDownOk);
  assign stopEdge = stopIn & ~s.stopPrev;
  assign stopClear = stopEdge & ~s.cfg[DPSR_CFG_STOP_KEEP_BIT];
  assign pwrEdge = powerDownIn & ~s.pwrPrev;
  assign tick = (s.tickCnt == TICK_CYCLES - 16'h0001);
  assign negUnipolar = unipolarMode & s.value[15];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    next_s.nvWr = 1'b0;
    next_s.rdData = '0;
    next_s.stopPrev = stopIn;
    next_s.pwrPrev = powerDownIn;
    next_s.upOwner = {adapterUpOk, tbUpOk};
    next_s.downOwner = {adapterDownOk, tbDownOk};
    next_s.valueOut = s.value;
    next_s.target = s.value;
    next_s.tickCnt = tick ? '0 : s.tickCnt + 16'h0001;

    // writes act on the running logic with no stop needed
    if (regWrStrobe)
    begin
      if (regAddr == DPSR_OFS_RATE)
      begin
        next_s.rate = regWrData[15:0];
      end
      else if (regAddr == DPSR_OFS_CFG)
      begin
        next_s.cfg = regWrData[1:0];
      end
      else if (regAddr == DPSR_OFS_POT_MASK)
      begin
        next_s.potMask = regWrData[DPSR_ADAPTERS-1:0];
      end
      else if (regAddr == DPSR_OFS_LOGIC_MASK)
      begin
        next_s.logicMask = regWrData[DPSR_ADAPTERS-1:0];
      end
    end

    // unmapped addresses read as zero; every mapped address is readable
    if (regRdStrobe)
    begin
      if (regAddr == DPSR_OFS_RATE)
      begin
        next_s.rdData = {16'h0000, s.rate};
      end
      else if (regAddr == DPSR_OFS_CFG)
      begin
        next_s.rdData = {30'h00000000, s.cfg};
      end
      else if (regAddr == DPSR_OFS_POT_MASK)
      begin
        next_s.rdData = 32'(s.potMask);
      end
      else if (regAddr == DPSR_OFS_LOGIC_MASK)
      begin
        next_s.rdData = 32'(s.logicMask);
      end
      else if (regAddr == DPSR_OFS_VALUE)
      begin
        next_s.rdData = {{16{s.value[15]}}, s.value};
      end
      else if (regAddr == DPSR_OFS_UP_OWNER)
      begin
        next_s.rdData = 32'(s.upOwner);
      end
      else if (regAddr == DPSR_OFS_DOWN_OWNER)
      begin
        next_s.rdData = 32'(s.downOwner);
      end
      else if (regAddr == DPSR_OFS_STATUS)
      begin
        next_s.rdData = {29'h00000000, s.phase, unipolarMode, stopIn};
      end
    end

    case (s.phase)
      DPSR_INIT:
      begin
        // reload only when the saved image says it was kept
        if (nvLoadValid && nvLoadSave)
        begin
          next_s.value = nvLoadValue;
        end
        else
        begin
          next_s.value = '0;
        end
        next_s.frac = '0;
        next_s.phase = DPSR_RUN;
      end
      DPSR_RUN:
      begin
        // fault has no path here; only the stop edge and a negative value in unipolar mode clear
        if (stopClear)
        begin
          next_s.value = '0;
          next_s.frac = '0;
        end
        else if (negUnipolar)
        begin
          next_s.value = '0;
          next_s.frac = '0;
        end
        else if (upAny ^ downAny)
        begin
          // one unit per clock drains the accumulator well inside a tick
          if (s.frac >= DPSR_FRAC_DIV)
          begin
            next_s.frac = s.frac - DPSR_FRAC_DIV;
            if (upAny)
            begin
              if (s.value < DPSR_VALUE_MAX)
              begin
                next_s.value = s.value + 16'sh0001;
              end
            end
            else if (unipolarMode && s.value <= 16'sh0000)
            begin
              next_s.value = s.value;
            end
            else if (s.value > -DPSR_VALUE_MAX)
            begin
              next_s.value = s.value - 16'sh0001;
            end
          end
          // guard bit stops wrap when ticks are shortened in simulation
          if (tick && !next_s.frac[16])
          begin
            next_s.frac = next_s.frac + {1'b0, s.rate};
          end
        end
        else
        begin
          next_s.frac = '0;
        end

        if (pwrEdge)
        begin
          next_s.nvWr = 1'b1;
          next_s.nvValue = s.value;
          next_s.nvSave = s.cfg[DPSR_CFG_SAVE_BIT];
        end
      end
      default:
      begin
        next_s = DPSR_RESET_STATE;
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      s <= DPSR_RESET_STATE;
    end
    else
    begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // the speed source selection downstream decides whether to use it
  assign rampTargetOut = s.target;
  assign potValueOut = s.valueOut;
  assign regRdData = s.rdData;
  assign upOwner = s.upOwner;
  assign downOwner = s.downOwner;
  assign nvWriteStrobe = s.nvWr;
  assign nvWriteValue = s.nvValue;
  assign nvWriteSave = s.nvSave;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_stop_clear: assert property (
    @(posedge ref_clk) disable iff (reset)
    (s.phase == DPSR_RUN && stopIn && !s.stopPrev && !s.cfg[1]) |=> (s.value == 16'sh0000))
    else $error("stop edge did not clear reference");

  a_stop_once: assert property (
    @(posedge ref_clk) disable iff (reset)
    (s.phase == DPSR_RUN && stopIn && s.stopPrev && !s.cfg[1] && upAny && !downAny
     && !unipolarMode && s.frac >= DPSR_FRAC_DIV && s.value < DPSR_VALUE_MAX)
    |=> (s.value == $past(s.value) + 16'sh0001))
    else $error("held stop kept clearing reference");

  a_both_hold: assert property (
    @(posedge ref_clk) disable iff (reset)
    (s.phase == DPSR_RUN && upAny && downAny && !stopClear && !negUnipolar)
    |=> ($stable(s.value) && s.frac == 17'h00000))
    else $error("reference moved with both commands");

  a_idle_hold: assert property (
    @(posedge ref_clk) disable iff (reset)
    (s.phase == DPSR_RUN && !upAny && !downAny && !stopClear && !negUnipolar)
    |=> $stable(s.value))
    else $error("reference moved with no command");

  a_unipolar_floor: assert property (
    @(posedge ref_clk) disable iff (reset)
    (s.phase == DPSR_RUN && unipolarMode) |=> !s.value[15])
    else $error("negative reference in unipolar mode");

  a_adapter_gate: assert property (
    @(posedge ref_clk) disable iff (reset)
    1'b1 |=> (s.upOwner[DPSR_ADAPTERS:1] == $past(adapterUpReq & s.potMask & s.logicMask)
              && s.downOwner[DPSR_ADAPTERS:1]
                 == $past(adapterDownReq & s.potMask & s.logicMask)))
    else $error("adapter owner bits not gated by masks");

  a_terminal_owner: assert property (
    @(posedge ref_clk) disable iff (reset)
    (tbUpIn && tbAssignUp) |=> s.upOwner[0])
    else $error("terminal input did not claim ownership");

  a_step_size: assert property (
    @(posedge ref_clk) disable iff (reset)
    ($past(s.phase) == DPSR_RUN && s.value != 16'sh0000)
    |-> (s.value == $past(s.value) || s.value == $past(s.value) + 16'sh0001
         || s.value == $past(s.value) - 16'sh0001))
    else $error("reference jumped by more than one unit");

  a_value_publish: assert property (
    @(posedge ref_clk) disable iff (reset)
    (regRdStrobe && regAddr == DPSR_OFS_VALUE)
    |=> (s.rdData == {{16{$past(s.value[15])}}, $past(s.value)}
         && s.valueOut == $past(s.value)))
    else $error("published reference wrong");

  a_nv_save: assert property (
    @(posedge ref_clk) disable iff (reset)
    (s.phase == DPSR_RUN && powerDownIn && !s.pwrPrev)
    |=> (s.nvWr && s.nvValue == $past(s.value) && s.nvSave == $past(s.cfg[0]))
    ##1 !s.nvWr)
    else $error("power-down save wrong");

  a_init_load: assert property (
    @(posedge ref_clk) disable iff (reset)
    (s.phase == DPSR_INIT)
    |=> (s.phase == DPSR_RUN
         && s.value == (($past(nvLoadValid) && $past(nvLoadSave)) ? $past(nvLoadValue)
                        : 16'sh0000)))
    else $error("power-up reference wrong");

  a_rate_write: assert property (
    @(posedge ref_clk) disable iff (reset)
    (regWrStrobe && regAddr == DPSR_OFS_RATE) |=> (s.rate == $past(regWrData[15:0])))
    else $error("rate write not applied");

  a_cfg_write: assert property (
    @(posedge ref_clk) disable iff (reset)
    (regWrStrobe && regAddr == DPSR_OFS_CFG) |=> (s.cfg == $past(regWrData[1:0])))
    else $error("config write not applied");

  a_mask_write: assert property (
    @(posedge ref_clk) disable iff (reset)
    (regWrStrobe && regAddr == DPSR_OFS_POT_MASK)
    |=> (s.potMask == $past(regWrData[DPSR_ADAPTERS-1:0])))
    else $error("pot mask write not applied");

  a_target_follow: assert property (
    @(posedge ref_clk) disable iff (reset)
    1'b1 |=> (s.target == $past(s.value) && s.valueOut == $past(s.value)))
    else $error("ramp target does not follow reference");

  a_terminal_down: assert property (
    @(posedge ref_clk) disable iff (reset)
    (tbDownIn && tbAssignDown) |=> s.downOwner[0])
    else $error("terminal down input did not claim ownership");

  a_bipolar_down: assert property (
    @(posedge ref_clk) disable iff (reset)
    (s.phase == DPSR_RUN && !unipolarMode && downAny && !upAny && !stopClear
     && s.frac >= DPSR_FRAC_DIV && s.value > -DPSR_VALUE_MAX)
    |=> (s.value == $past(s.value) - 16'sh0001))
    else $error("bipolar decrement did not step down");

  a_upper_limit: assert property (
    @(posedge ref_clk) disable iff (reset)
    (s.phase == DPSR_RUN && s.value <= DPSR_VALUE_MAX) |=> (s.value <= DPSR_VALUE_MAX))
    else $error("reference rose above its limit");

endmodule : dpsr_top

/* File: testbench/dpsr_cmd_model.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------
// command sources: terminal inputs and adapter ports
// ----------------------------------------------------------------
module dpsr_cmd_model
  import dpsr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic wantUp,
  input wire logic wantDown,
  input wire logic [DPSR_ADAPTERS:0] srcSel,
  output logic tbUpIn,
  output logic tbDownIn,
  output logic [DPSR_ADAPTERS-1:0] adapterUpReq,
  output logic [DPSR_ADAPTERS-1:0] adapterDownReq
);
  initial
  begin
    tbUpIn = 1'b0;
    tbDownIn = 1'b0;
    adapterUpReq = '0;
    adapterDownReq = '0;
  end

  // levels change only after an edge and stay up for the whole hold
  always @(posedge ref_clk)
  begin
    tbUpIn <= wantUp & srcSel[0];
    tbDownIn <= wantDown & srcSel[0];
    adapterUpReq <= {DPSR_ADAPTERS{wantUp}} & srcSel[DPSR_ADAPTERS:1];
    adapterDownReq <= {DPSR_ADAPTERS{wantDown}} & srcSel[DPSR_ADAPTERS:1];
  end
endmodule : dpsr_cmd_model

/* File: testbench/dpsr_top_tb.sv */
`timescale 1ns/1ps

module dpsr_top_tb
  import dpsr_pkg::*;
;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic regWrStrobe = 1'b0;
  logic regRdStrobe = 1'b0;
  logic [31:0] regRdData;
  logic tbUpIn, tbDownIn;
  logic tbAssignUp = 1'b1;
  logic tbAssignDown = 1'b1;
  logic [DPSR_ADAPTERS-1:0] adapterUpReq, adapterDownReq;
  logic stopIn = 1'b0;
  logic unipolarMode = 1'b0;
  logic powerDownIn = 1'b0;
  logic nvLoadValid = 1'b0;
  logic nvLoadSave = 1'b0;
  logic signed [15:0] nvLoadValue = 16'sh0000;
  logic nvWriteStrobe, nvWriteSave;
  logic signed [15:0] nvWriteValue, potValueOut, rampTargetOut;
  logic [DPSR_ADAPTERS:0] upOwner, downOwner;
  logic wantUp = 1'b0;
  logic wantDown = 1'b0;
  logic [DPSR_ADAPTERS:0] srcSel = 7'h01;
  int errCount = 0;
  int nTests = 0;
  int v0, v1;
  logic [31:0] d;

  initial
  begin
    forever #20 ref_clk = ~ref_clk;
  end

  // short tick keeps a run of many steps within budget
  dpsr_top #(.TICK_CYCLES(16'd100)) i_dut (.ref_clk(ref_clk), .reset(reset),
    .regAddr(regAddr), .regWrData(regWrData), .regWrStrobe(regWrStrobe),
    .regRdStrobe(regRdStrobe), .regRdData(regRdData), .tbUpIn(tbUpIn),
    .tbDownIn(tbDownIn), .tbAssignUp(tbAssignUp), .tbAssignDown(tbAssignDown),
    .adapterUpReq(adapterUpReq), .adapterDownReq(adapterDownReq), .stopIn(stopIn),
    .unipolarMode(unipolarMode), .powerDownIn(powerDownIn), .nvLoadValid(nvLoadValid),
    .nvLoadSave(nvLoadSave), .nvLoadValue(nvLoadValue), .nvWriteStrobe(nvWriteStrobe),
    .nvWriteValue(nvWriteValue), .nvWriteSave(nvWriteSave), .potValueOut(potValueOut),
    .rampTargetOut(rampTargetOut), .upOwner(upOwner), .downOwner(downOwner));

  dpsr_cmd_model i_src (.ref_clk(ref_clk), .wantUp(wantUp), .wantDown(wantDown),
    .srcSel(srcSel), .tbUpIn(tbUpIn), .tbDownIn(tbDownIn),
    .adapterUpReq(adapterUpReq), .adapterDownReq(adapterDownReq));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp)
    begin
      errCount++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic hold(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : hold

  task automatic wr(input logic [7:0] a, input logic [31:0] w);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= w;
    regWrStrobe <= 1'b1;
    @(posedge ref_clk);
    regWrStrobe <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    @(posedge ref_clk);
    regAddr <= a;
    regRdStrobe <= 1'b1;
    @(posedge ref_clk);
    regRdStrobe <= 1'b0;
    #1;
    r = regRdData;
  endtask : rd

  task automatic rdv(output int v);
    logic [31:0] r;
    rd(DPSR_OFS_VALUE, r);
    v = $signed(r);
  endtask : rdv

  // n cycles of command, then release and let outputs settle
  task automatic drive(input logic u, input logic dn, input logic [6:0] sel, input int n);
    wantUp <= u;
    wantDown <= dn;
    srcSel <= sel;
    hold(n);
    wantUp <= 1'b0;
    wantDown <= 1'b0;
    hold(5);
  endtask : drive

  task automatic do_reset;
    reset <= 1'b1;
    hold(10);
    reset <= 1'b0;
    hold(2);
  endtask : do_reset

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", nTests, errCount);
    if (errCount == 0 && nTests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    rd(DPSR_OFS_RATE, d); check("rate rst", d, 32'h64);
    rd(DPSR_OFS_CFG, d); check("cfg rst", d, 32'h2);
    rd(DPSR_OFS_POT_MASK, d); check("pmask rst", d, 32'h3F);
    rd(DPSR_OFS_LOGIC_MASK, d); check("lmask rst", d, 32'h3F);
    wr(DPSR_OFS_VALUE, 32'h55);
    rd(DPSR_OFS_VALUE, d); check("value ro", d, 32'h0);
    rd(8'h20, d); check("unmapped", d, 32'h0);
  endtask : t_regs

  // 1000 cycles hold 10 ticks; edge tick may be lost to release
  task automatic t_ramp;
    wr(DPSR_OFS_RATE, 32'h3E8);
    rdv(v0);
    wantUp <= 1'b1;
    srcSel <= 7'h01;
    hold(3);
    check("tb owner", upOwner, 7'h01);
    drive(1'b1, 1'b0, 7'h01, 997);
    rdv(v1);
    check("up slope", (v1 - v0 >= 9) && (v1 - v0 <= 10), 1'b1);
    check("owner off", upOwner, 7'h00);
    wr(DPSR_OFS_RATE, 32'h7D0);
    drive(1'b0, 1'b1, 7'h01, 1000);
    rdv(v0);
    check("down slope", (v1 - v0 >= 18) && (v1 - v0 <= 20), 1'b1);
    drive(1'b1, 1'b1, 7'h01, 600);
    rdv(v1);
    check("both hold", v1, v0);
    tbAssignUp <= 1'b0;
    drive(1'b1, 1'b0, 7'h01, 600);
    rdv(v0);
    check("unassigned", v0, v1);
    tbAssignUp <= 1'b1;
  endtask : t_ramp

  task automatic t_direction;
    wantDown <= 1'b1;
    srcSel <= 7'h01;
    hold(3);
    check("down owner", downOwner, 7'h01);
    drive(1'b0, 1'b1, 7'h01, 2000);
    rdv(v0);
    check("down off", downOwner, 7'h00);
    check("negative", v0 < 0, 1'b1);
    check("pub value", 32'($signed(potValueOut)), 32'(v0));
    check("ramp tgt", rampTargetOut, potValueOut);
    unipolarMode <= 1'b1;
    hold(4);
    check("forced zero", potValueOut, 16'h0000);
    drive(1'b0, 1'b1, 7'h01, 600);
    check("clamp zero", potValueOut, 16'h0000);
  endtask : t_direction

  task automatic t_masks;
    wr(DPSR_OFS_POT_MASK, 32'h3B);
    drive(1'b1, 1'b0, 7'h08, 600);
    check("pmask block", potValueOut, 16'h0000);
    wr(DPSR_OFS_POT_MASK, 32'h3F);
    wr(DPSR_OFS_LOGIC_MASK, 32'h3B);
    drive(1'b1, 1'b0, 7'h08, 600);
    check("lmask block", potValueOut, 16'h0000);
    wr(DPSR_OFS_LOGIC_MASK, 32'h3F);
    wantUp <= 1'b1;
    srcSel <= 7'h08;
    hold(3);
    check("adapter owner", upOwner, 7'h08);
    drive(1'b1, 1'b0, 7'h08, 600);
    check("adapter up", potValueOut > 0, 1'b1);
  endtask : t_masks

  task automatic t_stop;
    wr(DPSR_OFS_CFG, 32'h0);
    stopIn <= 1'b1;
    hold(3);
    check("stop clear", potValueOut, 16'h0000);
    drive(1'b1, 1'b0, 7'h01, 600);
    check("held stop", potValueOut > 0, 1'b1);
    stopIn <= 1'b0;
    wr(DPSR_OFS_CFG, 32'h2);
    rdv(v0);
    stopIn <= 1'b1;
    hold(3);
    rdv(v1);
    check("stop keep", v1, v0);
    stopIn <= 1'b0;
  endtask : t_stop

  task automatic t_power;
    int k;
    wr(DPSR_OFS_CFG, 32'h3);
    rdv(v0);
    powerDownIn <= 1'b1;
    k = 0;
    do
    begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    while (nvWriteStrobe !== 1'b1 && k < 5);
    check("nv strobe", nvWriteStrobe, 1'b1);
    check("nv value", 32'($signed(nvWriteValue)), 32'(v0));
    check("nv save", nvWriteSave, 1'b1);
    powerDownIn <= 1'b0;
    nvLoadValid <= 1'b1;
    nvLoadSave <= 1'b1;
    nvLoadValue <= 16'sh0123;
    do_reset();
    rd(DPSR_OFS_VALUE, d); check("reload", d, 32'h123);
    nvLoadValid <= 1'b0;
    do_reset();
    rd(DPSR_OFS_VALUE, d); check("no image", d, 32'h0);
  endtask : t_power

  initial
  begin
    do_reset();
    t_regs();
    t_ramp();
    t_direction();
    t_masks();
    t_stop();
    t_power();
    wrap_up();
  end
endmodule : dpsr_top_tb
